// ===== src/disk_status_params.svh
// offsets, field positions, reset values and timing counts for the disk status block
`ifndef DISK_STATUS_PARAMS_SVH
`define DISK_STATUS_PARAMS_SVH
`define ADDR_PARAM_WORD    4'h0
`define ADDR_STATUS_WORD   4'h1
`define ADDR_CAUSE_LATCH   4'h2
`define ADDR_UTIL_STATE    4'h3
`define ADDR_WIDTH         4
`define POS_UNIT           0
`define POS_CLASS          1
`define POS_RSVD2          2
`define POS_DELETED        3
`define POS_READY          4
`define POS_RETRY          5
`define POS_WPROT          6
`define POS_TWO_SIDED      7
`define POS_SHIP           7
`define POS_CODE_LO        8
`define POS_LAMP_LO        8
`define POS_TRACK0         14
`define POS_SEEK_DONE      15
`define POS_SUBTEST_LO     8
`define UTIL_RSVD_MASK     16'hf87c
`define STATUS_RESET       16'h0000
`define XFER_TIMEOUT_MS    20
`define CLK_HZ             25000000
`define XFER_TIMEOUT_CYC   ((`XFER_TIMEOUT_MS * `CLK_HZ) / 1000)
`endif

// ===== src/disk_status_pkg.sv
// types shared by the disk status block
package disk_status_pkg;
  typedef enum logic [5:0] {
    ec_none         = 6'h00,
    ec_bad_head     = 6'h01,
    ec_bad_sector   = 6'h02,
    ec_bad_cylinder = 6'h03,
    ec_bad_logical  = 6'h04,
    ec_register_to  = 6'h05,
    ec_bad_drv_type = 6'h07,
    ec_head_select  = 6'h09,
    ec_wr_protect   = 6'h0a,
    ec_deleted_data = 6'h0b,
    ec_seek_error   = 6'h0f,
    ec_data_crc     = 6'h12,
    ec_xfer_timeout = 6'h15,
    ec_flaw_map_bad = 6'h1b,
    ec_flawed_sect  = 6'h21,
    ec_internal     = 6'h30
  } err_code_t;
  typedef enum logic [1:0] {
    cmd_other,
    cmd_seek,
    cmd_maint,
    cmd_utility
  } cmd_kind_t;
endpackage : disk_status_pkg

// ===== src/xfer_watchdog.sv
// watchdog that abandons a host memory access left pending too long
`include "disk_status_params.svh"
module xfer_watchdog #(
  parameter int unsigned LIMIT = `XFER_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic req,
  input  wire logic ack,
  output logic      abandon,
  output logic      expired
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  logic [CW-1:0] cnt_q;
  logic          exp_q;
  wire           at_limit = (cnt_q == CW'(LIMIT - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= (req && !ack && !at_limit) ? cnt_q + CW'(1) : '0;
      exp_q <= req && !ack && at_limit;
    end
  end

  assign abandon = req && !ack && at_limit;
  assign expired = exp_q;
endmodule : xfer_watchdog

// ===== src/error_priority.sv
// picks the single error code reported for a command
module error_priority
  import disk_status_pkg::*;
(
  input  wire logic [15:0] cause,
  input  wire logic        skip_deleted,
  input  wire logic        logical_mode,
  input  wire logic        internal_fault,
  output err_code_t        code
);
  // cause bit order is the priority order; the flaw map fault sits above the crc bit, the access timeout below it
  // so a bad flaw map read never hides behind a data check failure
  localparam err_code_t table_c [16] = '{
    ec_internal, ec_flaw_map_bad, ec_bad_drv_type, ec_wr_protect,
    ec_bad_head, ec_bad_sector, ec_bad_cylinder, ec_bad_logical,
    ec_register_to, ec_head_select, ec_seek_error, ec_flawed_sect,
    ec_deleted_data, ec_data_crc, ec_xfer_timeout, ec_none
  };
  logic [15:0] live;
  always_comb begin
    live = cause;
    live[0] = internal_fault;
    live[11] = cause[11] && !logical_mode;
    live[12] = cause[12] && !skip_deleted;
    live[15] = 1'b0;
    code = ec_none;
    for (int i = 15; i >= 0; i--) begin
      if (live[i]) begin
        code = table_c[i];
      end
    end
  end
endmodule : error_priority

// ===== src/disk_status_utility.sv
// completion status word builder and utility/maintenance parameter decoder
//
// Contract
// - maintenance word: bits 1,0 unit, upper subtest
// - lamp bits 10..8 drive three indicators
// - bit 7 parks selected fixed drive
// - status word posted at command end
// - bit 15: explicit seek finished on unit
// - bit 14: head at track zero
// - bits 13..8 error code, zero none
// - codes 1-4 for address range faults
// - code 5 registration timeout
// - code 7 unused drive type
// - code 9 wrong head after revolution
// - code 10 write to protected media
// - code 11 deleted mark unless skipping; the code raises it for floppy units only
// - code 21 after 20 ms access timeout
// - code 15 wrong cylinder after positioning
// - code 27 no flaw map; access over crc
// - code 33 flawed sector, physical addressing
// - 35-47 unused, 48-63 internal faults
// - bit 7 two-sided only for floppy
// - bits 6,4,3 protect, ready, deleted mark
// - bit 5 retries or correction used
// - error flag implies nonzero code
//
// Decided for this implementation: strobed register access and the address map.
`include "disk_status_params.svh"
module disk_status_utility
  import disk_status_pkg::*;
#(
  parameter int unsigned XFER_LIMIT = `XFER_TIMEOUT_CYC,
  parameter int unsigned LAMPS      = 3
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [`ADDR_WIDTH-1:0] addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [15:0]            rdata,
  input  wire disk_status_pkg::cmd_kind_t cmd_kind,
  input  wire logic                   cmd_start,
  input  wire logic                   cmd_end,
  input  wire logic                   cmd_fail,
  input  wire logic                   done_flag,
  input  wire logic                   seek_complete,
  input  wire logic                   track_zero,
  input  wire logic                   unit_ready,
  input  wire logic                   unit_protected,
  input  wire logic                   write_protect_jumper,
  input  wire logic                   ext_protect_open,
  input  wire logic                   two_sided_media,
  input  wire logic                   eight_inch,
  input  wire logic                   legacy_format,
  input  wire logic                   deleted_mark_seen,
  input  wire logic                   deleted_skip_enable,
  input  wire logic                   logical_addressing,
  input  wire logic                   retry_event,
  input  wire logic [15:0]            fault_events,
  input  wire logic                   mem_req,
  input  wire logic                   mem_ack,
  output logic                        mem_abandon,
  output logic      [LAMPS-1:0]       lamps,
  output logic                        ship_zone_park,
  output logic      [1:0]             drive_select,
  output logic      [7:0]             subtest,
  output logic                        status_valid,
  output logic                        error_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // register bus decode
  function automatic logic hit(input logic [`ADDR_WIDTH-1:0] a, input logic [`ADDR_WIDTH-1:0] off);
    hit = (a == off);
  endfunction : hit

  wire param_wr  = wr && hit(addr, `ADDR_PARAM_WORD);
  wire status_rd = rd && hit(addr, `ADDR_STATUS_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0]      status_q, status_d;
  logic [15:0]      cause_q;
  logic [LAMPS-1:0] lamps_q;
  logic             park_q;
  logic [1:0]       unit_q;
  logic [7:0]       subtest_q;
  logic             seek_cmd_q;
  logic             seek_done_q;
  logic             retry_q;
  logic             deleted_q;
  logic             valid_q;
  logic             err_q;
  logic [15:0]      rdata_q;
  err_code_t        code;
  logic             timeout_hit;

  xfer_watchdog #(.LIMIT(XFER_LIMIT)) u_wdog (
    .clk     (clk),
    .rstn    (rstn),
    .req     (mem_req),
    .ack     (mem_ack),
    .abandon (mem_abandon),
    .expired (timeout_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // cause collection: bit positions follow the priority table
  wire media_protect = unit_protected || (unit_q == 2'b10 && (!write_protect_jumper || ext_protect_open));
  wire [15:0] cause_new = {1'b0,
                           timeout_hit,
                           fault_events[13],
                           deleted_mark_seen && !unit_q[1],
                           fault_events[11],
                           fault_events[10:4],
                           fault_events[3],
                           fault_events[2:0]};

  error_priority u_prio (
    .cause          (cause_q),
    .skip_deleted   (deleted_skip_enable),
    .logical_mode   (logical_addressing),
    .internal_fault (cause_q[0]),
    .code           (code)
  );

  // an error termination with no recorded cause still reports an internal fault
  wire [5:0] final_code = (cmd_fail && code == ec_none) ? 6'(ec_internal) : 6'(code);
  wire       is_floppy  = !unit_q[1];
  wire       two_sided  = is_floppy && (eight_inch ? two_sided_media : !legacy_format);

  always_comb begin
    status_d = `STATUS_RESET;
    status_d[`POS_SEEK_DONE] = seek_done_q;
    status_d[`POS_TRACK0] = track_zero;
    status_d[`POS_CODE_LO +: 6] = final_code;
    status_d[`POS_TWO_SIDED] = two_sided;
    status_d[`POS_WPROT] = media_protect;
    status_d[`POS_RETRY] = retry_q || retry_event;
    status_d[`POS_READY] = unit_ready;
    status_d[`POS_DELETED] = deleted_q || deleted_mark_seen;
    status_d[`POS_RSVD2] = 1'b0;
    status_d[`POS_CLASS] = unit_q[1];
    status_d[`POS_UNIT] = unit_q[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter word capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unit_q    <= 2'h0;
      subtest_q <= 8'h00;
      lamps_q   <= '0;
      park_q    <= 1'b0;
    end else if (param_wr) begin
      unit_q <= wdata[1:0];
      park_q <= (cmd_kind == cmd_utility) && wdata[`POS_SHIP] && wdata[`POS_CLASS];
      if (cmd_kind == cmd_maint) begin
        subtest_q <= wdata[15:8];
      end
      if (cmd_kind == cmd_utility) begin
        lamps_q <= wdata[`POS_LAMP_LO +: LAMPS];
      end
    end else begin
      park_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-command event flags; a new event beats the clear at command start
  // a seek completion seen at command start counts only for the new command
  wire seek_live = cmd_start ? (cmd_kind == cmd_seek) : seek_cmd_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cause_q     <= 16'h0000;
      retry_q     <= 1'b0;
      deleted_q   <= 1'b0;
      seek_cmd_q  <= 1'b0;
      seek_done_q <= 1'b0;
    end else begin
      cause_q     <= (cmd_start ? 16'h0000 : cause_q) | cause_new;
      retry_q     <= (!cmd_start && retry_q) || retry_event;
      deleted_q   <= (!cmd_start && deleted_q) || deleted_mark_seen;
      seek_cmd_q  <= cmd_start ? (cmd_kind == cmd_seek) : seek_cmd_q;
      seek_done_q <= (!cmd_start && seek_done_q) || (seek_live && seek_complete);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion word, posted when the command ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= `STATUS_RESET;
      valid_q  <= 1'b0;
      err_q    <= 1'b0;
    end else if (cmd_end) begin
      status_q <= status_d;
      valid_q  <= 1'b1;
      err_q    <= cmd_fail;
    end else if (cmd_start) begin
      valid_q <= 1'b0;
      err_q   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: the word is only handed out while done is set
  wire [15:0] rd_mux = status_rd ? (done_flag ? status_q : 16'h0000) :
                       (rd && hit(addr, `ADDR_CAUSE_LATCH)) ? cause_q :
                       (rd && hit(addr, `ADDR_UTIL_STATE)) ?
                         {5'h00, lamps_q, park_q, subtest_q[4:0], unit_q} : 16'h0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign rdata          = rdata_q;
  assign lamps          = lamps_q;
  assign ship_zone_park = park_q;
  assign drive_select   = unit_q;
  assign subtest        = subtest_q;
  assign status_valid   = valid_q;
  assign error_flag     = err_q;
endmodule : disk_status_utility

// ===== verif/disk_status_monitor.sv
// port-level assertions for the disk status block
`include "disk_status_params.svh"
module status_monitor #(
  parameter int unsigned LAMPS = 3
) (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic [`ADDR_WIDTH-1:0]     addr,
  input wire logic [15:0]                wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [15:0]                rdata,
  input wire disk_status_pkg::cmd_kind_t cmd_kind,
  input wire logic                       done_flag,
  input wire logic                       error_flag,
  input wire logic [LAMPS-1:0]           lamps,
  input wire logic                       ship_zone_park,
  input wire logic [1:0]                 drive_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import disk_status_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [15:0] wd_q;
  wire logic pw = wr && addr == `ADDR_PARAM_WORD;
  wire logic uw = pw && cmd_kind == cmd_utility;
  wire logic sr = rd && addr == `ADDR_STATUS_WORD;
  // word written last cycle, compared with what the outputs settle to
  always_ff @(posedge clk) wd_q <= wdata;
  ////////////////////////////////////////////////////////////////
  property p_lamps; uw |=> lamps == wd_q[`POS_LAMP_LO +: LAMPS]; endproperty
  a_lamps: assert property (p_lamps) else $error("lamps wrong");
  property p_park; uw && wdata[7] && wdata[1] |=> ship_zone_park ##1 !ship_zone_park; endproperty
  a_park: assert property (p_park) else $error("park pulse wrong");
  property p_park_fixed; uw && !wdata[1] |=> !ship_zone_park; endproperty
  a_park_fixed: assert property (p_park_fixed) else $error("floppy parked");
  property p_unit; pw && cmd_kind inside {cmd_utility, cmd_maint} |=> drive_select == wd_q[1:0]; endproperty
  a_unit: assert property (p_unit) else $error("unit bits wrong");
  property p_gate; sr && !done_flag |=> rdata == 16'h0000; endproperty
  a_gate: assert property (p_gate) else $error("status read while busy");
  property p_err_code; sr && done_flag && error_flag |=> rdata[13:8] != 6'h00; endproperty
  a_err_code: assert property (p_err_code) else $error("error without code");
  property p_rsvd; sr |=> !rdata[`POS_RSVD2]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_spare; sr |=> !(rdata[13:8] inside {[6'd35:6'd47]}); endproperty
  a_spare: assert property (p_spare) else $error("spare code used");
endmodule : status_monitor
bind disk_status_utility status_monitor #(.LAMPS(LAMPS)) u_status_monitor (
  .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .cmd_kind, .done_flag,
  .error_flag, .lamps, .ship_zone_park, .drive_select
);

// ===== verif/drive_model.sv
// drive-side stand-in: head position of the selected drive
module drive_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic park,
  input  wire logic home,
  output logic      track_zero,
  output logic      seek_complete
);
  timeunit 1ns;
  timeprecision 1ns;
  // heads come out of reset registered at track zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      track_zero <= 1'b1;
      seek_complete <= 1'b1;
    end else begin
      track_zero <= home | (track_zero & !park);
      seek_complete <= !(home | park);
    end
  end
endmodule : drive_model

// ===== verif/disk_status_utility_report_test.sv
// self-checking bench for the disk status block
`include "disk_status_params.svh"
module disk_status_utility_report_test;
  timeunit 1ns;
  timeprecision 1ns;
  import disk_status_pkg::*;
  localparam int unsigned LIM = 20;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, cmd_start = 0, cmd_end = 0, cmd_fail = 0;
  logic        done_flag = 0, ready = 0, prot = 0, jumper = 1, ext_open = 0, two_sided = 0;
  logic        eight = 0, legacy = 0, del = 0, skip = 0, logical = 0, retry = 0, to = 0;
  logic        mem_req = 0, mem_ack = 0, home = 0, park, tz, sc, abandon, valid, err;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, faults = 16'h0000, rdata, w, f, e;
  logic [2:0]  lamps;
  logic [1:0]  ds, unit = 2'h0;
  logic [7:0]  sub;
  cmd_kind_t   kind = cmd_other;
  int          miscompares = 0, cmp_count = 0, cycles = 0, seed = 32'h2e78acc9, n, r;
  int          code_of[16] = '{48, 27, 7, 10, 1, 2, 3, 4, 5, 9, 15, 33, 0, 18, 0, 0};
  always #20 clk = ~clk;
  disk_status_utility #(.XFER_LIMIT(LIM)) dut (
    .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .cmd_kind(kind), .cmd_start, .cmd_end,
    .cmd_fail, .done_flag, .seek_complete(sc), .track_zero(tz), .unit_ready(ready),
    .unit_protected(prot), .write_protect_jumper(jumper), .ext_protect_open(ext_open),
    .two_sided_media(two_sided), .eight_inch(eight), .legacy_format(legacy),
    .deleted_mark_seen(del), .deleted_skip_enable(skip), .logical_addressing(logical),
    .retry_event(retry), .fault_events(faults), .mem_req, .mem_ack, .mem_abandon(abandon),
    .lamps, .ship_zone_park(park), .drive_select(ds), .subtest(sub), .status_valid(valid),
    .error_flag(err)
  );
  drive_model u_drive (.clk, .rstn, .park, .home, .track_zero(tz), .seek_complete(sc));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
  endtask : tick
  task automatic put(input logic [3:0] a, input logic [15:0] d);
    wr <= 1;
    addr <= a;
    wdata <= d;
    tick;
    wr <= 0;
  endtask : put
  task automatic get(input logic [3:0] a, output logic [15:0] v);
    rd <= 1;
    addr <= a;
    tick;
    rd <= 0;
    #1 v = rdata;
    tick;
  endtask : get
  // expected status word; lowest fault bit wins, unused event bits carry no code
  function automatic logic [15:0] model(input logic [15:0] fv, input logic fail);
    int c;
    logic [15:0] m;
    m = fv & 16'h2fff;
    m[11] = m[11] & !logical;
    c = 0;
    for (int i = 15; i >= 0; i--) if (m[i]) c = code_of[i];
    if (c == 0) c = to ? 21 : fv[12] && !skip && !unit[1] ? 11 : fail ? 48 : 0;
    return {kind == cmd_seek && sc, tz, 6'(c), !unit[1] && (eight ? two_sided : !legacy),
            prot | (unit == 2'h2 && (!jumper | ext_open)), fv[14], ready, fv[12], 1'b0, unit};
  endfunction : model
  task automatic run(input logic [15:0] fv, input logic fail);
    logic ab;
    ab = 0;
    cmd_start <= 1;
    tick;
    cmd_start <= 0;
    faults <= fv;
    del <= fv[12];
    retry <= fv[14];
    mem_req <= 1;
    for (n = 1; n < 40; n++) begin
      tick;
      faults <= 0;
      del <= 0;
      retry <= 0;
      #1 ab = ab | (abandon === 1'b1);
      if (ab || (!to && n == 3)) break;
    end
    // a timed-out access is held until the abandon is taken, then the latched cause settles
    mem_ack <= !to;
    tick;
    mem_ack <= 0;
    mem_req <= 0;
    tick;
    chk("abandon", ab, to);
    if (to) chk("wait", n >= LIM - 1 && n <= LIM + 1, 1);
    cmd_end <= 1;
    cmd_fail <= fail;
    tick;
    cmd_end <= 0;
    done_flag <= 1;
    get(`ADDR_STATUS_WORD, w);
    done_flag <= 0;
    chk("error flag", {err, valid}, {fail, 1'b1});
  endtask : run
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) tick;
    rstn <= 1;
    tick;
    chk("idle", {lamps, ds, sub, park, valid, err}, 0);
    done_flag <= 1;
    get(`ADDR_STATUS_WORD, w);
    done_flag <= 0;
    chk("reset word", w, `STATUS_RESET);
    for (int i = 0; i < 8; i++) begin
      kind <= cmd_utility;
      put(`ADDR_PARAM_WORD, {5'h0, 3'(i), i[0], 5'h0, 2'(i)});
      #1 chk("lamps", {lamps, ds, park}, {3'(i), 2'(i), i[0] & i[1]});
      tick;
      #1 chk("park end", park, 0);
    end
    r = $random(seed);
    kind <= cmd_maint;
    put(`ADDR_PARAM_WORD, {r[7:0], 6'h00, r[9:8]});
    #1 chk("maint", {sub, ds}, {r[7:0], r[9:8]});
    put(4'hf, 16'hffff);
    get(4'hf, w);
    chk("unmapped", w, 0);
    for (int i = 0; i < 50; i++) begin
      r = $random(seed);
      f = i < 16 ? 16'h1 << i : i < 48 ? 16'(r) & 16'hefff : 16'h0;
      to = i == 48;
      kind <= cmd_utility;
      unit = r[28:27];
      put(`ADDR_PARAM_WORD, {5'h0, r[29:27], r[30], 5'h0, r[28:27]});
      home <= r[31];
      {ready, prot, two_sided, eight, legacy, logical, jumper, ext_open, skip} <= r[24:16];
      kind <= cmd_kind_t'(r[26:25]);
      tick;
      home <= 0;
      e = model(f, i > 47);
      run(f, e[13:8] != 0);
      chk("status", w, model(f, i > 47));
    end
    get(`ADDR_STATUS_WORD, w);
    chk("busy read", w, 0);
    give_verdict();
  end
endmodule : disk_status_utility_report_test
